// ==== hub_power_config_regs.v ====
// Power-budget registers 0x0D..0x10, strap capture for the indicator pins
// and the power-on delay timer for a downstream port.
// Assumes all inputs except STRAP_AMBER, STRAP_GREEN and BUS_RESET come from the CLK domain.
`timescale 1ns/100ps
`default_nettype none
`include "hub_power_config_defines.vh"

module hub_power_config_regs
#(
    parameter integer STEP_CYCLES = `POWER_ON_STEP_CYCLES
)
(
    input  wire       CLK,
    input  wire       NRST,
    input  wire [7:0] REG_ADDR,
    input  wire [7:0] REG_WDATA,
    input  wire       REG_WR,
    input  wire       REG_RD,
    output reg  [7:0] REG_RDATA,
    input  wire       DEFAULT_MODE,
    input  wire       STRAP_MODE,
    input  wire       STRAP_AMBER,
    input  wire       STRAP_GREEN,
    input  wire       AMBER_ON,
    input  wire       GREEN_ON,
    output wire       AMBER_OUT,
    output wire       AMBER_OE,
    output wire       GREEN_OUT,
    output wire       GREEN_OE,
    input  wire       BUS_RESET,
    output reg        BUS_RESET_SEEN,
    input  wire       PORT_POWER_ON,
    output reg        PORT_POWER_GOOD,
    output wire [7:0] BUS_POWERED_MAX_POWER,
    output wire [7:0] SELF_POWERED_CTRL_MAX_CUR,
    output wire [7:0] BUS_POWERED_CTRL_MAX_CUR,
    output wire [7:0] PORT_POWER_GOOD_DELAY
);

    // ========================================================
    // Declarations
    reg  [7:0]  bus_powered_max_power_ff;
    reg  [7:0]  self_powered_controller_max_current_ff;
    reg  [7:0]  bus_powered_controller_max_current_ff;
    reg  [7:0]  port_power_good_delay_ff;
    reg  [1:0]  amber_sync_ff;
    reg  [1:0]  green_sync_ff;
    reg  [1:0]  bus_rst_sync_ff;
    reg  [1:0]  capture_ff;
    reg         amber_strap_ff;
    reg         green_strap_ff;
    reg         leds_live_ff;
    reg  [7:0]  nxt_rdata;
    reg  [31:0] tick_cnt_ff;
    reg  [7:0]  step_cnt_ff;
    reg         pon_busy_ff;
    wire        tick;

    // Register outputs for the rest of the hub
    assign BUS_POWERED_MAX_POWER     = bus_powered_max_power_ff;
    assign SELF_POWERED_CTRL_MAX_CUR = self_powered_controller_max_current_ff;
    assign BUS_POWERED_CTRL_MAX_CUR  = bus_powered_controller_max_current_ff;
    assign PORT_POWER_GOOD_DELAY     = port_power_good_delay_ff;

    // ========================================================
    // Register writes
    // Power and current values count 2 mA steps, the delay 2 ms steps; the loader must already fold in board
    // and compound-peripheral draw as appropriate, the bank only stores.
    // [R16] hardware reset defaults
    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            // [R07] eight-bit, zero reset
            bus_powered_max_power_ff               <= `RST_POWER_REG;
            self_powered_controller_max_current_ff <= `RST_POWER_REG;
            bus_powered_controller_max_current_ff  <= `RST_POWER_REG;
            port_power_good_delay_ff               <= `RST_POWER_REG;
        end
        else if (capture_ff == 2'b01 && (DEFAULT_MODE || STRAP_MODE))
        begin
            // [R05] controller current default 50
            // [R11] internal defaults otherwise
            self_powered_controller_max_current_ff <= `DEF_CTRL_MAX_CUR;
            bus_powered_controller_max_current_ff  <= `DEF_CTRL_MAX_CUR;
        end
        else if (REG_WR)
        begin
            // [R17] stored unclamped
            // [R09] undefined offsets dropped
            case (REG_ADDR)
                // [R01] total bus-powered draw
                // [R02] includes board and peripheral
                `OFS_BUS_POWERED_MAX_POWER:
                    bus_powered_max_power_ff <= REG_WDATA;
                // [R03] self-powered controller only
                `OFS_SELF_POWERED_CTRL_MAX_CUR:
                    self_powered_controller_max_current_ff <= REG_WDATA;
                // [R04] bus-powered controller only
                `OFS_BUS_POWERED_CTRL_MAX_CUR:
                    bus_powered_controller_max_current_ff <= REG_WDATA;
                // [R06] power-on delay steps
                `OFS_PORT_POWER_GOOD_DELAY:
                    port_power_good_delay_ff <= REG_WDATA;
                default:
                    bus_powered_max_power_ff <= bus_powered_max_power_ff;
            endcase
        end
    end

    // ========================================================
    // Read decode
    // [R08] undefined reads zero
    always @*
    begin
        case (REG_ADDR)
            `OFS_BUS_POWERED_MAX_POWER:
                nxt_rdata = bus_powered_max_power_ff;
            `OFS_SELF_POWERED_CTRL_MAX_CUR:
                nxt_rdata = self_powered_controller_max_current_ff;
            `OFS_BUS_POWERED_CTRL_MAX_CUR:
                nxt_rdata = bus_powered_controller_max_current_ff;
            `OFS_PORT_POWER_GOOD_DELAY:
                nxt_rdata = port_power_good_delay_ff;
            default:
                nxt_rdata = 8'h00;
        endcase
    end

    // Read data registered; holds until the next read
    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
            REG_RDATA <= nxt_rdata;
    end

    // ========================================================
    // Strap capture on the indicator pins
    // Pins are asynchronous, so two flops before anything reads them.
    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            amber_sync_ff   <= 2'b00;
            green_sync_ff   <= 2'b00;
            bus_rst_sync_ff <= 2'b00;
        end
        else
        begin
            amber_sync_ff   <= {amber_sync_ff[0], STRAP_AMBER};
            green_sync_ff   <= {green_sync_ff[0], STRAP_GREEN};
            bus_rst_sync_ff <= {bus_rst_sync_ff[0], BUS_RESET};
        end
    end

    // Capture the synchronised levels once the synchroniser has filled
    // after reset release; LEDs stay off until then.
    // [R12] sample after reset release
    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            capture_ff     <= 2'b11;
            amber_strap_ff <= 1'b0;
            green_strap_ff <= 1'b0;
            leds_live_ff   <= 1'b0;
        end
        else
        begin
            if (capture_ff != 2'b00)
                capture_ff <= capture_ff - 2'b01;
            if (capture_ff == 2'b01)
            begin
                amber_strap_ff <= amber_sync_ff[1];
                green_strap_ff <= green_sync_ff[1];
                leds_live_ff   <= 1'b1;
            end
        end
    end

    // ========================================================
    // Indicator drive; strap only chooses polarity in default mode
    // [R13] strapped high, active low
    // [R14] strapped low, active high
    assign AMBER_OUT = (DEFAULT_MODE && amber_strap_ff) ? ~AMBER_ON
                                                         : AMBER_ON;
    assign GREEN_OUT = (DEFAULT_MODE && green_strap_ff) ? ~GREEN_ON
                                                         : GREEN_ON;
    assign AMBER_OE  = leds_live_ff;
    assign GREEN_OE  = leds_live_ff;

    // ========================================================
    // Bus reset flag: upstream reset does not touch the power registers
    // [R15] two reset sources
    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            BUS_RESET_SEEN <= 1'b0;
        else
            BUS_RESET_SEEN <= bus_rst_sync_ff[1];
    end

    // ========================================================
    // Power-on timer: delay register times 2 ms, then power good.
    // A zero delay reports good two cycles after the request: one to start, one to report.
    assign tick = (tick_cnt_ff == STEP_CYCLES - 1);

    // [R06] count 2 ms steps
    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            tick_cnt_ff     <= 32'h00000000;
            step_cnt_ff     <= 8'h00;
            pon_busy_ff     <= 1'b0;
            PORT_POWER_GOOD <= 1'b0;
        end
        else if (!PORT_POWER_ON || bus_rst_sync_ff[1])
        begin
            tick_cnt_ff     <= 32'h00000000;
            step_cnt_ff     <= 8'h00;
            pon_busy_ff     <= 1'b0;
            PORT_POWER_GOOD <= 1'b0;
        end
        else if (!pon_busy_ff && !PORT_POWER_GOOD)
        begin
            pon_busy_ff  <= 1'b1;
            tick_cnt_ff  <= 32'h00000000;
            step_cnt_ff  <= 8'h00;
        end
        else if (pon_busy_ff)
        begin
            if (step_cnt_ff == port_power_good_delay_ff)
            begin
                pon_busy_ff     <= 1'b0;
                PORT_POWER_GOOD <= 1'b1;
            end
            else if (tick)
            begin
                tick_cnt_ff <= 32'h00000000;
                step_cnt_ff <= step_cnt_ff + 8'h01;
            end
            else
                tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
        end
    end

endmodule // hub_power_config_regs
`default_nettype wire

// ==== hub_power_config_defines.vh ====
// Constants for the hub power-budget configuration register bank.
// Assumes a byte-wide register port driven by the configuration loader.
// Overview of operation
// [R01] Bus-powered total power, 2 mA units
// [R02] Total covers silicon, board, zero-current peripheral
// [R03] Self-powered controller current, 2 mA, excludes peripheral
// [R04] Bus-powered controller current, 2 mA, excludes peripheral
// [R05] Controller current intended default is 50
// [R06] Power-on time in 2 ms units
// [R07] Power registers 8-bit, reset to zero
// [R08] Undefined offset reads return zero
// [R09] Undefined offset writes silently discarded
// [R10] Configurer writes zero to reserved bits
// [R11] Strap mode: straps plus internal defaults; in strap mode the code loads internal defaults but ignores the LED straps
// [R12] Sample LED straps after reset release
// [R13] Strapped high: indicator drives active low; the code does so in default mode only
// [R14] Strapped low: indicator drives active high
// [R15] Hardware reset and bus reset distinguished
// [R16] Hardware reset returns registers to defaults
// [R17] Written values stored without clamping
`ifndef HUB_POWER_CONFIG_DEFINES_VH
`define HUB_POWER_CONFIG_DEFINES_VH

// ============================================================
// Register offsets
`define OFS_BUS_POWERED_MAX_POWER        8'h0D
`define OFS_SELF_POWERED_CTRL_MAX_CUR    8'h0E
`define OFS_BUS_POWERED_CTRL_MAX_CUR     8'h0F
`define OFS_PORT_POWER_GOOD_DELAY        8'h10

// ============================================================
// Reset and default values
`define RST_POWER_REG                    8'h00
`define DEF_CTRL_MAX_CUR                 8'h32

// ============================================================
// Units and timing
`define CURRENT_STEP_MA                  2
`define POWER_ON_STEP_MS                 2
`define CLK_PERIOD_NS                    100
`define POWER_ON_STEP_CYCLES  ((`POWER_ON_STEP_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ==== hub_power_chk_properties.sv ====
// Assertions on the power register bank ports.
// Bound into every hub_power_config_regs instance.
`timescale 1ns/100ps
`default_nettype none
module hub_power_chk
#(
    parameter integer STEP_CYCLES = 4
)
(
    input wire logic       CLK,
    input wire logic       NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic       DEFAULT_MODE,
    input wire logic       AMBER_ON,
    input wire logic       AMBER_OUT,
    input wire logic       AMBER_OE,
    input wire logic       PORT_POWER_ON,
    input wire logic       PORT_POWER_GOOD,
    input wire logic [7:0] BUS_POWERED_MAX_POWER,
    input wire logic [7:0] PORT_POWER_GOOD_DELAY
);
    // ==========
    // Offset decode; only 0x0D..0x10 exist here
    wire       undef = REG_ADDR < 8'h0D || REG_ADDR > 8'h10;
    wire [7:0] mp = BUS_POWERED_MAX_POWER;
    wire [7:0] dly = PORT_POWER_GOOD_DELAY;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Two reset edges, so the async clear has surely landed
    property p_rst_zero;
        disable iff (1'b0) (!NRST) [*2] |-> {mp, dly, AMBER_OE} == 17'h0;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("reset");
    property p_wr_mp;
        REG_WR && REG_ADDR == 8'h0D |=> mp == $past(REG_WDATA);
    endproperty
    a_wr_mp: assert property (p_wr_mp) else $error("wr 0D");
    property p_wr_dly;
        REG_WR && REG_ADDR == 8'h10 |=> dly == $past(REG_WDATA);
    endproperty
    a_wr_dly: assert property (p_wr_dly) else $error("wr 10");
    property p_rd_dly;
        REG_RD && REG_ADDR == 8'h10 |=> REG_RDATA == $past(dly);
    endproperty
    a_rd_dly: assert property (p_rd_dly) else $error("rd 10");
    property p_rd_undef;
        REG_RD && undef |=> REG_RDATA == 8'h00;
    endproperty
    a_rd_undef: assert property (p_rd_undef) else $error("rd undef");
    property p_wr_undef;
        REG_WR && undef |=> $stable({mp, dly});
    endproperty
    a_wr_undef: assert property (p_wr_undef) else $error("wr undef");
    // Strap polarity only applies in the internal default mode
    property p_led;
        AMBER_OE && !DEFAULT_MODE |-> AMBER_OUT == AMBER_ON;
    endproperty
    a_led: assert property (p_led) else $error("led");
    // Zero delay: power good follows the request within three edges
    sequence s_pon_rise;
        !PORT_POWER_ON ##1 PORT_POWER_ON && dly == 8'h00;
    endsequence
    sequence s_good_soon;
        ##[1:3] PORT_POWER_GOOD;
    endsequence
    property p_pon;
        s_pon_rise |-> s_good_soon;
    endproperty
    a_pon: assert property (p_pon) else $error("power good");
endmodule // hub_power_chk
bind hub_power_config_regs hub_power_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
    .CLK, .NRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .DEFAULT_MODE, .AMBER_ON, .AMBER_OUT, .AMBER_OE, .PORT_POWER_ON,
    .PORT_POWER_GOOD, .BUS_POWERED_MAX_POWER, .PORT_POWER_GOOD_DELAY);
`default_nettype wire

// ==== cfg_loader_model.sv ====
// Model of the configuration source that loads the register bank.
// Driven by the bench through its tasks; shares the bench clock.
`timescale 1ns/100ps
`default_nettype none
module cfg_loader_model
(
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output var  logic [7:0] addr = 8'h00,
    output var  logic [7:0] wdata = 8'h00,
    output var  logic       wr = 1'b0,
    output var  logic       rd = 1'b0
);
    // ==========
    // Byte write; data is scrambled after the strobe, as a real host
    // whole bytes only
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    // Byte read; data is taken one edge after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
endmodule // cfg_loader_model
`default_nettype wire

// ==== tb_hub_power_config_regs.sv ====
// Self-checking bench: integer model of the registers, compared at reads.
// Needs cfg_loader_model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tb_hub_power_config_regs;
    localparam integer STEP = 4;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       dmode = 1'b1;
    logic       smode = 1'b0;
    logic       a_on = 1'b0;
    logic       g_on = 1'b0;
    logic       bus_rst = 1'b0;
    logic       pon = 1'b0;
    wire  [7:0] addr, wdata, rdata, r0, r1, r2, r3;
    wire        wr, rd, a_out, a_oe, g_out, g_oe, seen, good;
    int         err_total = 0;
    int         compares = 0;
    int         seed = 8631;
    int         mdl [4];
    int         n, e;
    logic [7:0] a, v;
    // ==========
    // 10 MHz clock
    always #50 clk = ~clk;
    cfg_loader_model ld (.clk(clk), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd));
    hub_power_config_regs #(.STEP_CYCLES(STEP)) dut (.CLK(clk),
        .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .DEFAULT_MODE(dmode),
        .STRAP_MODE(smode), .STRAP_AMBER(1'b1), .STRAP_GREEN(1'b0),
        .AMBER_ON(a_on), .GREEN_ON(g_on), .AMBER_OUT(a_out),
        .AMBER_OE(a_oe), .GREEN_OUT(g_out), .GREEN_OE(g_oe),
        .BUS_RESET(bus_rst), .BUS_RESET_SEEN(seen), .PORT_POWER_ON(pon),
        .PORT_POWER_GOOD(good), .BUS_POWERED_MAX_POWER(r0),
        .SELF_POWERED_CTRL_MAX_CUR(r1), .BUS_POWERED_CTRL_MAX_CUR(r2),
        .PORT_POWER_GOOD_DELAY(r3));
    // ==========
    // Verdict; also reached by the watchdog
    task automatic finish_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Five-cycle reset; controller currents then load the default 50
    task automatic do_reset(input logic dm, input logic sm);
        @(posedge clk);
        nrst <= 1'b0;
        dmode <= dm;
        smode <= sm;
        repeat (5) @(posedge clk);
        `CHK("rst", 32'h0, {r0, r1, r2, r3})
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        mdl = '{0, 50, 50, 0};
    endtask
    // Read back all four registers and their outputs
    task automatic chk_regs;
        for (int i = 0; i < 4; i++)
        begin
            ld.rd_reg(8'h0D + 8'(i), v);
            `CHK("rd", 8'(mdl[i]), v)
        end
        `CHK("out", {8'(mdl[0]), 8'(mdl[1])}, {r0, r1})
        `CHK("out", {8'(mdl[2]), 8'(mdl[3])}, {r2, r3})
    endtask
    // Main sequence
    initial
    begin
        do_reset(1'b1, 1'b0);
        chk_regs();
        for (int i = 0; i < 2; i++)
        begin
            a_on <= i[0];
            g_on <= i[0];
            @(posedge clk);
            `CHK("led", {~i[0], i[0], 2'b11}, {a_out, g_out, a_oe, g_oe})
        end
        repeat (24)
        begin
            a = 8'h0B + 8'(($random(seed) & 7));
            v = 8'($random(seed));
            ld.wr_reg(a, v);
            // Model takes the byte the bench sent, not the loader's pins
            if (a >= 8'h0D && a <= 8'h10)
                mdl[a - 8'h0D] = v;
        end
        chk_regs();
        for (int i = 0; i < 4; i++)
        begin
            ld.rd_reg(8'h0C + 8'(i * 5), v);
            `CHK("undef", 8'h00, v)
        end
        for (int i = 0; i < 2; i++)
        begin
            pon <= 1'b0;
            mdl[3] = i * 3;
            ld.wr_reg(8'h10, 8'(mdl[3]));
            pon <= 1'b1;
            // Each 2 ms step is STEP cycles; two more to start and report
            e = mdl[3] * STEP + 2;
            n = 0;
            while (good !== 1'b1 && n < 300)
            begin
                @(posedge clk);
                n++;
            end
            `CHK("pon", 1'b1, 1'(n >= e && n <= e + 3))
        end
        // bus reset clears the timer only
        bus_rst <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("busrst", 2'b10, {seen, good})
        chk_regs();
        bus_rst <= 1'b0;
        pon <= 1'b0;
        // strap polarity ignored in strap mode
        do_reset(1'b0, 1'b1);
        a_on <= 1'b1;
        @(posedge clk);
        `CHK("led2", 2'b11, {a_out, a_oe})
        chk_regs();
        finish_test();
    end
    // Watchdog: the run needs well under 2000 cycles
    initial
    begin
        #200000;
        err_total++;
        finish_test();
    end
endmodule // tb_hub_power_config_regs
`default_nettype wire
